// file: core/tx_cfg_pkg.sv
package tx_cfg_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_TX_POWER_SET1   = 8'h1d;
   localparam logic [7:0] ADDR_ASK_LOW_POWER   = 8'h1e;
   localparam logic [7:0] ADDR_AMP_RAMP        = 8'h1f;
   localparam logic [7:0] ADDR_TX_CONTROL      = 8'h20;

   // writable bits per register, all others read as zero
   localparam logic [7:0] MASK_TX_POWER_SET1   = 8'h9f;
   localparam logic [7:0] MASK_ASK_LOW_POWER   = 8'h1f;
   localparam logic [7:0] MASK_AMP_RAMP        = 8'h7f;
   localparam logic [7:0] MASK_TX_CONTROL      = 8'hfb;

   localparam logic [7:0] RST_TX_POWER_SET1    = 8'h00;
   localparam logic [7:0] RST_ASK_LOW_POWER    = 8'h00;
   localparam logic [7:0] RST_AMP_RAMP         = 8'h00;
   localparam logic [7:0] RST_TX_CONTROL       = 8'h01;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ASK_SEL_BIT      = 7;
   localparam int POWER_MSB        = 4;
   localparam int RAMP_EXP_MSB     = 6;
   localparam int RAMP_EXP_LSB     = 5;
   localparam int RAMP_MANT_MSB    = 4;
   localparam int SD_DOUBLE_BIT    = 7;
   localparam int POL_INV_BIT      = 6;
   localparam int CLK_SRC_BIT      = 5;
   localparam int CLK_OUT_MSB      = 4;
   localparam int CLK_OUT_LSB      = 3;
   localparam int PA_LEVEL_MSB     = 1;

   // ----------------------------------------------------------------
   // clock output select codes
   // ----------------------------------------------------------------
   localparam logic [1:0] CLKOUT_TX    = 2'h0;
   localparam logic [1:0] CLKOUT_TX_X2 = 2'h1;
   localparam logic [1:0] CLKOUT_TX_X4 = 2'h2;
   localparam logic [1:0] CLKOUT_NONE  = 2'h3;

   // ----------------------------------------------------------------
   // receive frequency offset codes
   // ----------------------------------------------------------------
   localparam logic [10:0] RX_OFFSET_NOMINAL = 11'h266;   // 614
   localparam logic [10:0] RX_OFFSET_HALF    = 11'h133;   // 307
   localparam logic [10:0] RX_OFFSET_DOUBLE  = 11'h4cc;   // 1228

   typedef enum logic [0:0] {
      TX_IDLE   = 1'b0,
      TX_ACTIVE = 1'b1
   } tx_state_t;

   // snapshot of the modulator settings held during one command; the doubling bit is read live from the register
   typedef struct packed {
      logic       ask;
      logic [4:0] high_power;
      logic [4:0] low_power;
      logic [1:0] ramp_exp;
      logic [4:0] ramp_mant;
      logic       invert;
      logic       clk_src;
      logic [1:0] clk_out_sel;
      logic [1:0] pa_level;
   } tx_cfg_t;

endpackage : tx_cfg_pkg

// file: core/tx_symbol_map.sv
`timescale 1ns/10ps
module tx_symbol_map (
   input  wire logic data_bit,
   input  wire logic invert,
   input  wire logic manchester,
   input  wire logic second_half,
   output logic      symbol
);

   // symbol 0: centre plus deviation / high power word
   always_comb begin
      symbol = data_bit ^ invert;
      if (manchester && second_half) begin
         symbol = ~symbol;
      end
   end

endmodule : tx_symbol_map

// file: core/tx_modulation_power_control.sv
// Function
// - second set ASK bit selects ASK
// - flag F=1 uses second set high power
// - ASK symbol one uses low power word
// - ramp exponent 6:5, mantissa 4:0
// - ramp applied in FSK frames too
// - data 0 gives plus deviation/high power
// - invert bit swaps data mapping
// - Manchester second half inverts first half
// - clock source bit picks bit/chip clock
// - clock output select drives clock pin
// - 00 tx, 01 x2, 10 x4, 11 none
// - PA supply level field, reset 01
// - doubling bit configures delta-sigma modulator
// - offset 614, 307 or 1228
// - flag F=0 uses first set
`timescale 1ns/10ps
module tx_modulation_power_control (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic        tx_start,
   input  wire logic        tx_stop,
   input  wire logic        tx_flag_f,
   input  wire logic        set0_ask,
   input  wire logic [4:0]  set0_high_power,
   input  wire logic        tx_data,
   input  wire logic        manchester_en,
   input  wire logic        second_half,
   input  wire logic        bit_clk_tick,
   input  wire logic        chip_clk_tick,
   input  wire logic        tx_clk_x2_tick,
   input  wire logic        tx_clk_x4_tick,
   input  wire logic        lo_divider_select,
   output logic             tx_active,
   output logic             tx_clk_tick,
   output logic             aux_clock_pin,
   output logic             mod_is_ask,
   output logic      [4:0]  pa_power_word,
   output logic             fsk_dev_positive,
   output logic             ramp_enable,
   output logic      [1:0]  amp_ramp_exponent,
   output logic      [4:0]  amp_ramp_mantissa,
   output logic      [1:0]  pa_supply_level,
   output logic             sd_result_doubling,
   output logic      [10:0] rx_offset_code
);

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [7:0] power_set1_reg,  power_set1_next;
   logic [7:0] low_power_reg,   low_power_next;
   logic [7:0] ramp_reg,        ramp_next;
   logic [7:0] tx_control_reg,  tx_control_next;
   logic [7:0] rdata_reg,       rdata_next;

   always_comb begin
      power_set1_next = power_set1_reg;
      low_power_next  = low_power_reg;
      ramp_next       = ramp_reg;
      tx_control_next = tx_control_reg;
      rdata_next      = rdata_reg;
      if (reg_wr) begin
         if (reg_addr == tx_cfg_pkg::ADDR_TX_POWER_SET1) begin
            power_set1_next = reg_wdata & tx_cfg_pkg::MASK_TX_POWER_SET1;
         end else if (reg_addr == tx_cfg_pkg::ADDR_ASK_LOW_POWER) begin
            low_power_next = reg_wdata & tx_cfg_pkg::MASK_ASK_LOW_POWER;
         end else if (reg_addr == tx_cfg_pkg::ADDR_AMP_RAMP) begin
            ramp_next = reg_wdata & tx_cfg_pkg::MASK_AMP_RAMP;
         end else if (reg_addr == tx_cfg_pkg::ADDR_TX_CONTROL) begin
            tx_control_next = reg_wdata & tx_cfg_pkg::MASK_TX_CONTROL;
         end
      end
      if (reg_rd) begin
         if (reg_addr == tx_cfg_pkg::ADDR_TX_POWER_SET1) begin
            rdata_next = power_set1_reg;
         end else if (reg_addr == tx_cfg_pkg::ADDR_ASK_LOW_POWER) begin
            rdata_next = low_power_reg;
         end else if (reg_addr == tx_cfg_pkg::ADDR_AMP_RAMP) begin
            rdata_next = ramp_reg;
         end else if (reg_addr == tx_cfg_pkg::ADDR_TX_CONTROL) begin
            rdata_next = tx_control_reg;
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         power_set1_reg <= tx_cfg_pkg::RST_TX_POWER_SET1;
         low_power_reg  <= tx_cfg_pkg::RST_ASK_LOW_POWER;
         ramp_reg       <= tx_cfg_pkg::RST_AMP_RAMP;
         tx_control_reg <= tx_cfg_pkg::RST_TX_CONTROL;
         rdata_reg      <= 8'h00;
      end else begin
         power_set1_reg <= power_set1_next;
         low_power_reg  <= low_power_next;
         ramp_reg       <= ramp_next;
         tx_control_reg <= tx_control_next;
         rdata_reg      <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ----------------------------------------------------------------
   // live settings and command snapshot
   // ----------------------------------------------------------------
   tx_cfg_pkg::tx_cfg_t   live_cfg, cfg_reg, cfg_next;
   tx_cfg_pkg::tx_state_t state_reg, state_next;

   always_comb begin
      live_cfg.ask        = tx_flag_f ? power_set1_reg[tx_cfg_pkg::ASK_SEL_BIT]
                                      : set0_ask;
      live_cfg.high_power = tx_flag_f ? power_set1_reg[tx_cfg_pkg::POWER_MSB:0]
                                      : set0_high_power;
      live_cfg.low_power  = low_power_reg[tx_cfg_pkg::POWER_MSB:0];
      live_cfg.ramp_exp   = ramp_reg[tx_cfg_pkg::RAMP_EXP_MSB:tx_cfg_pkg::RAMP_EXP_LSB];
      live_cfg.ramp_mant  = ramp_reg[tx_cfg_pkg::RAMP_MANT_MSB:0];
      live_cfg.invert     = tx_control_reg[tx_cfg_pkg::POL_INV_BIT];
      live_cfg.clk_src    = tx_control_reg[tx_cfg_pkg::CLK_SRC_BIT];
      live_cfg.clk_out_sel = tx_control_reg[tx_cfg_pkg::CLK_OUT_MSB:tx_cfg_pkg::CLK_OUT_LSB];
      live_cfg.pa_level   = tx_control_reg[tx_cfg_pkg::PA_LEVEL_MSB:0];
   end

   // start is only taken from idle; once active, stop wins over start in the same cycle and the new frame is lost
   always_comb begin
      state_next = state_reg;
      cfg_next   = cfg_reg;
      case (state_reg)
         tx_cfg_pkg::TX_IDLE: begin
            if (tx_start) begin
               state_next = tx_cfg_pkg::TX_ACTIVE;
               cfg_next   = live_cfg;
            end
         end
         tx_cfg_pkg::TX_ACTIVE: begin
            if (tx_stop) begin
               state_next = tx_cfg_pkg::TX_IDLE;
            end
         end
         default: state_next = tx_cfg_pkg::TX_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= tx_cfg_pkg::TX_IDLE;
         cfg_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cfg_reg   <= cfg_next;
      end
   end

   assign tx_active = (state_reg == tx_cfg_pkg::TX_ACTIVE);

   // ----------------------------------------------------------------
   // clocks
   // ----------------------------------------------------------------
   // manchester only works from the bit clock; software must choose it
   assign tx_clk_tick = cfg_reg.clk_src ? bit_clk_tick : chip_clk_tick;

   always_comb begin
      aux_clock_pin = 1'b0;
      if (tx_active) begin
         case (cfg_reg.clk_out_sel)
            tx_cfg_pkg::CLKOUT_TX:    aux_clock_pin = tx_clk_tick;
            tx_cfg_pkg::CLKOUT_TX_X2: aux_clock_pin = tx_clk_x2_tick;
            tx_cfg_pkg::CLKOUT_TX_X4: aux_clock_pin = tx_clk_x4_tick;
            default:                  aux_clock_pin = 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // modulation outputs
   // ----------------------------------------------------------------
   logic symbol;

   tx_symbol_map tx_symbol_map_i (
      .data_bit    (tx_data),
      .invert      (cfg_reg.invert),
      .manchester  (manchester_en),
      .second_half (second_half),
      .symbol      (symbol)
   );

   logic [4:0]  power_reg, power_next;
   logic        dev_pos_reg, dev_pos_next;
   logic [10:0] offset_reg, offset_next;
   logic        sd_dbl;

   assign sd_dbl = tx_control_reg[tx_cfg_pkg::SD_DOUBLE_BIT];

   always_comb begin
      dev_pos_next = ~symbol;
      power_next   = cfg_reg.high_power;
      if (cfg_reg.ask && symbol) begin
         power_next = cfg_reg.low_power;
      end
      if (lo_divider_select == sd_dbl) begin
         offset_next = tx_cfg_pkg::RX_OFFSET_NOMINAL;
      end else if (sd_dbl) begin
         offset_next = tx_cfg_pkg::RX_OFFSET_HALF;
      end else begin
         offset_next = tx_cfg_pkg::RX_OFFSET_DOUBLE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         power_reg   <= 5'h00;
         dev_pos_reg <= 1'b1;
         offset_reg  <= tx_cfg_pkg::RX_OFFSET_NOMINAL;
      end else begin
         power_reg   <= power_next;
         dev_pos_reg <= dev_pos_next;
         offset_reg  <= offset_next;
      end
   end

   assign pa_power_word      = power_reg;
   assign fsk_dev_positive   = dev_pos_reg;
   assign rx_offset_code     = offset_reg;
   assign mod_is_ask         = cfg_reg.ask;
   assign ramp_enable        = tx_active;
   assign amp_ramp_exponent  = cfg_reg.ramp_exp;
   assign amp_ramp_mantissa  = cfg_reg.ramp_mant;
   assign pa_supply_level    = cfg_reg.pa_level;
   assign sd_result_doubling = sd_dbl;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_ask_set_one: assert property (
      !tx_active && tx_start && tx_flag_f
      |=> mod_is_ask == $past(power_set1_reg[tx_cfg_pkg::ASK_SEL_BIT]))
      else $error("ask select not taken from second set");
   a_ask_set_zero: assert property (
      !tx_active && tx_start && !tx_flag_f |=> mod_is_ask == $past(set0_ask))
      else $error("ask select not taken from first set");
   a_fsk_high_power: assert property (
      tx_active && !mod_is_ask ##1 tx_active |-> pa_power_word == cfg_reg.high_power)
      else $error("fsk power is not high word");
   a_ask_low_power: assert property (
      tx_active && mod_is_ask && symbol ##1 $stable(cfg_reg)
      |-> pa_power_word == cfg_reg.low_power)
      else $error("ask symbol one not using low word");
   a_dev_sign_map: assert property (
      !manchester_en |=> fsk_dev_positive == ($past(tx_data) == $past(cfg_reg.invert)))
      else $error("deviation sign mapping wrong");
   a_manchester_half: assert property (
      manchester_en && second_half |=> fsk_dev_positive
         == ($past(tx_data) != $past(cfg_reg.invert)))
      else $error("manchester second half not inverted");
   a_cfg_frozen: assert property (
      tx_active && !tx_stop |=> $stable(cfg_reg))
      else $error("settings changed during command");
   a_clk_none: assert property (
      cfg_reg.clk_out_sel == tx_cfg_pkg::CLKOUT_NONE || !tx_active |-> !aux_clock_pin)
      else $error("clock output driven when deselected");
   a_offset_code: assert property (
      ##1 $stable(sd_dbl) && $stable(lo_divider_select) && !lo_divider_select && sd_dbl
      |-> rx_offset_code == tx_cfg_pkg::RX_OFFSET_HALF)
      else $error("offset code wrong for doubling only");
   a_reserved_zero: assert property (
      (tx_control_reg & ~tx_cfg_pkg::MASK_TX_CONTROL) == 8'h00
      && (low_power_reg & ~tx_cfg_pkg::MASK_ASK_LOW_POWER) == 8'h00
      && (power_set1_reg & ~tx_cfg_pkg::MASK_TX_POWER_SET1) == 8'h00
      && (ramp_reg & ~tx_cfg_pkg::MASK_AMP_RAMP) == 8'h00)
      else $error("reserved bit set");

endmodule : tx_modulation_power_control

// file: sim/tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   logic        clk, rst, reg_wr, reg_rd, tx_start, tx_stop, tx_flag_f, set0_ask, tx_data;
   logic        manchester_en, second_half, bit_clk_tick, chip_clk_tick, tx_clk_x2_tick;
   logic        tx_clk_x4_tick, lo_divider_select, tx_active, tx_clk_tick, aux_clock_pin;
   logic        mod_is_ask, fsk_dev_positive, ramp_enable, sd_result_doubling;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, look_seq, seen;
   logic [4:0]  set0_high_power, pa_power_word, amp_ramp_mantissa, h1, h0, lo, hp;
   logic [1:0]  amp_ramp_exponent, pa_supply_level, sel, pa;
   logic [10:0] rx_offset_code;
   logic [3:0]  look_sel, tk;
   logic [6:0]  rmp;
   logic [31:0] lfsr;
   logic [15:0] note;
   logic        f, a1, ask, inv, man, s, txc;
   logic [15:0] exp_q[$];
   int          n_errors, comparisons;

   tx_modulation_power_control tx_modulation_power_control_i (.clk, .rst, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .tx_start, .tx_stop, .tx_flag_f, .set0_ask,
      .set0_high_power, .tx_data, .manchester_en, .second_half, .bit_clk_tick, .chip_clk_tick,
      .tx_clk_x2_tick, .tx_clk_x4_tick, .lo_divider_select, .tx_active, .tx_clk_tick,
      .aux_clock_pin, .mod_is_ask, .pa_power_word, .fsk_dev_positive, .ramp_enable,
      .amp_ramp_exponent, .amp_ramp_mantissa, .pa_supply_level, .sd_result_doubling,
      .rx_offset_code);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : next_rand

   function automatic logic [15:0] obs(input logic [3:0] k);
      case (k)
         4'h0: return {8'h00, reg_rdata};
         4'h1: return {15'h0000, tx_active};
         4'h2: return {15'h0000, mod_is_ask};
         4'h3: return {11'h000, pa_power_word};
         4'h4: return {15'h0000, fsk_dev_positive};
         4'h5: return {9'h000, amp_ramp_exponent, amp_ramp_mantissa};
         4'h6: return {14'h0000, pa_supply_level};
         4'h7: return {15'h0000, sd_result_doubling};
         4'h8: return {5'h00, rx_offset_code};
         4'h9: return {14'h0000, tx_clk_tick, aux_clock_pin};
         default: return {15'h0000, ramp_enable};
      endcase
   endfunction : obs

   // ----------------------------------------------------------------
   // monitor
   // ----------------------------------------------------------------
   // a new note is flagged by a sequence step, so back-to-back notes never collide
   always @(posedge clk) begin
      if (look_seq !== seen) begin
         seen = look_seq;
         note = exp_q.pop_front();
         `CHK(obs(look_sel), note)
      end
   end

   task automatic observe(input logic [3:0] k, input logic [15:0] v);
      exp_q.push_back(v);
      look_sel <= k;
      look_seq <= look_seq + 8'h01;
      @(posedge clk);
   endtask : observe

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      observe(4'h0, {8'h00, e});
   endtask : rd

   task automatic cmd(input logic stop, input logic flag);
      @(posedge clk);
      tx_stop   <= stop;
      tx_start  <= ~stop;
      tx_flag_f <= flag;
      @(posedge clk);
      tx_start <= 1'b0;
      tx_stop  <= 1'b0;
   endtask : cmd

   task automatic summarize;
      if (n_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   initial begin
      #200us;
      n_errors++;
      summarize();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst, reg_wr, reg_rd, tx_start, tx_stop, tx_flag_f, set0_ask, tx_data} = 8'h80;
      {manchester_en, second_half, bit_clk_tick, chip_clk_tick} = 4'h0;
      {tx_clk_x2_tick, tx_clk_x4_tick, lo_divider_select} = 3'h0;
      {reg_addr, reg_wdata, set0_high_power, look_seq, seen, look_sel} = '0;
      lfsr = 32'h6b77513e;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) rd(8'h1d + 8'(i), (i == 3) ? 8'h01 : 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(8'h1d + 8'(i), 8'hff);
         rd(8'h1d + 8'(i), (i == 0) ? 8'h9f : (i == 1) ? 8'h1f : (i == 2) ? 8'h7f : 8'hfb);
      end
      rd(8'h3c, 8'h00);
      for (int j = 0; j < 4; j++) begin
         lo_divider_select <= j[1];
         wr(8'h20, {j[0], 7'h01});
         @(posedge clk);
         observe(4'h8, (j == 1) ? 16'h0133 : (j == 2) ? 16'h04cc : 16'h0266);
         observe(4'h7, 16'(j[0]));
      end
      for (int k = 0; k < 16; k++) begin
         lfsr = next_rand(next_rand(lfsr));
         {h1, lo, h0, rmp, sel, pa, tk} = lfsr[29:0];
         {f, a1, inv, man} = 4'(k);
         ask = f ? a1 : lfsr[31];
         hp  = f ? h1 : h0;
         set0_ask        <= lfsr[31];
         set0_high_power <= h0;
         manchester_en   <= man;
         wr(8'h1d, {a1, 2'h0, h1});
         wr(8'h1e, {3'h0, lo});
         wr(8'h1f, {1'b0, rmp});
         wr(8'h20, {1'b0, inv, man, sel, 1'b0, pa});
         cmd(1'b0, f);
         observe(4'h1, 16'h0001);
         observe(4'ha, 16'h0001);
         observe(4'h2, 16'(ask));
         observe(4'h5, 16'(rmp));
         observe(4'h6, 16'(pa));
         wr(8'h1d, {~a1, 2'h0, ~h1});
         wr(8'h1e, {3'h0, ~lo});
         for (int d = 0; d < 4; d++) begin
            if (d[1] && !man) continue;
            s = d[0] ^ inv ^ d[1];
            @(posedge clk);
            tx_data     <= d[0];
            second_half <= d[1];
            @(posedge clk);
            observe(4'h3, 16'((s && ask) ? lo : hp));
            observe(4'h4, 16'(!s));
         end
         {bit_clk_tick, chip_clk_tick, tx_clk_x2_tick, tx_clk_x4_tick} <= tk;
         txc = man ? tk[3] : tk[2];
         @(posedge clk);
         observe(4'h9, {14'h0000, txc, (sel == 2'h0) ? txc : (sel == 2'h1) ? tk[1] :
                 (sel == 2'h2) ? tk[0] : 1'b0});
         cmd(1'b0, ~f);
         observe(4'h2, 16'(ask));
         cmd(1'b1, 1'b0);
         observe(4'h1, 16'h0000);
      end
      repeat (2) @(posedge clk);
      summarize();
   end
endmodule : tb_top
